// File: logic/event_sdo_defines.vh
`ifndef EVENT_SDO_DEFINES_VH
`define EVENT_SDO_DEFINES_VH
// register offsets
`define ADDR_LOSS_UP_LO   8'h06
`define ADDR_LOSS_UP_HI   8'h07
`define ADDR_LOSS_LOW_LO  8'h08
`define ADDR_LOSS_LOW_HI  8'h09
`define ADDR_EVENT_MODE   8'h0a
`define ADDR_IND_UP_LO    8'h16
`define ADDR_IND_UP_HI    8'h17
`define ADDR_IND_LOW_LO   8'h18
`define ADDR_IND_LOW_HI   8'h19
`define ADDR_STATUS       8'h20
`define ADDR_HIRES_FIRST  8'h38
`define ADDR_HIRES_LAST   8'h3a
// event mode fields
`define MODE_ROUTE_BIT    7
`define MODE_RESET        8'h00
`define MODE_CLEAR_VALUE  8'h80
`define SEL_NONE          6'h00
`define SEL_HIRES_READY   6'h20
`define SEL_IND_WINDOW    6'h10
`define SEL_IND_HIGH      6'h08
`define SEL_LOSS_IND_RDY  6'h04
`define SEL_LOSS_WINDOW   6'h02
`define SEL_LOSS_HIGH     6'h01
// status bit positions
`define ST_LOSS_HIGH      5
`define ST_LOSS_WINDOW    4
`define ST_IND_HIGH       3
`define ST_IND_WINDOW     2
// spi
`define SPI_CMD_BITS      4'h8
// timing: lead of ready release before completion
`define LEAD_NS           100
`define CLK_NS            25
`define LEAD_CYCLES       ((`LEAD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// File: logic/window_comparator.v
`timescale 1ns/1ps
`include "event_sdo_defines.vh"
module window_comparator #(
  parameter WIDTH = 16
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_valid,
  input  wire [WIDTH-1:0] i_result,
  input  wire [WIDTH-1:0] i_upper,
  input  wire [WIDTH-1:0] i_lower,
  input  wire             i_clear_latch,
  output reg              o_window,
  output reg              o_high_latch
);
  // window holds state between the limits, acts like a proximity switch
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_window     <= 1'b0;
      o_high_latch <= 1'b0;
    end else begin
      if (i_valid && (i_result > i_upper))
        o_window <= 1'b1;
      else if (i_valid && (i_result < i_lower))
        o_window <= 1'b0;
      // set wins over clear so an event is never dropped
      if (i_valid && (i_result > i_upper))
        o_high_latch <= 1'b1;
      else if (i_clear_latch)
        o_high_latch <= 1'b0;
    end
  end
endmodule // window_comparator

// File: logic/event_sdo_reporting_comparator.v
`timescale 1ns/1ps
`include "event_sdo_defines.vh"
// Summary of operation
// - hires conversion starts only after a reference clock edge is seen
// - mode bit 7 routes the event signal onto the data-out pin
// - low six mode bits pick the event source; zero means plain data-out
// - code 0x20 latches hires ready; code 0x04 pulses loss-ind ready
// - code 0x10 inductance window compare; 0x08 latched inductance high
// - code 0x02 loss window compare; 0x01 latched loss high
// - routing off: data-out floats until eighth falling sclk edge
// - routing on: data-out high from select until event, read, deselect
// - selected ready source asserts event at each matching completion
// - loss-ind ready releases shortly before each completion
// - hires ready latches low until hires result registers are read
// - loss and inductance results meet limits; hires never compared
// - window mode switches above upper limit and below lower limit
// - latching compare or continuous per-result compare both offered
// - limit registers writable during conversion, taking effect at once
// - writing 0x80 to mode clears latched event output
// - status bit 5 latched loss high, bit 4 loss window
// - status bit 3 latched inductance high, bit 2 inductance window
module event_sdo_reporting_comparator #(
  parameter WIDTH = 16,
  parameter LEAD  = `LEAD_CYCLES
) (
  input  wire             i_clk,
  input  wire             i_resetn,
  input  wire             i_ref_clock_in,
  input  wire             i_chip_select_n,
  input  wire             i_sclk,
  input  wire             i_reg_wr,
  input  wire             i_reg_rd,
  input  wire [7:0]       i_reg_addr,
  input  wire [7:0]       i_reg_wdata,
  input  wire             i_spi_read,
  input  wire             i_serial_data,
  input  wire             i_hires_request,
  input  wire             i_hires_done,
  input  wire             i_loss_ind_near,
  input  wire             i_loss_ind_done,
  input  wire [WIDTH-1:0] i_loss_result,
  input  wire [WIDTH-1:0] i_ind_result,
  output reg  [7:0]       o_reg_rdata,
  output reg              o_hires_start,
  output reg              o_dataout,
  output reg              o_dataout_oe,
  output reg              o_event_out
);
  reg [1:0] rst_sync;
  wire      rst_n = rst_sync[1];
  // reset released through two flops
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // pin inputs through two flops before use
  reg [1:0] ref_s;
  reg [1:0] cs_s;
  reg [1:0] sclk_s;
  reg       ref_d;
  reg       sclk_d;
  reg       cs_d;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_s  <= 2'b00;
      cs_s   <= 2'b11;
      sclk_s <= 2'b00;
      ref_d  <= 1'b0;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      ref_s  <= {ref_s[0], i_ref_clock_in};
      cs_s   <= {cs_s[0], i_chip_select_n};
      sclk_s <= {sclk_s[0], i_sclk};
      ref_d  <= ref_s[1];
      sclk_d <= sclk_s[1];
      cs_d   <= cs_s[1];
    end
  end
  wire ref_edge  = ref_s[1] & ~ref_d;
  wire sclk_fall = ~sclk_s[1] & sclk_d;
  wire cs_fall   = ~cs_s[1] & cs_d;
  wire cs_low    = ~cs_s[1];

  // registers
  reg [7:0] loss_up_lo;
  reg [7:0] loss_up_hi;
  reg [7:0] loss_low_lo;
  reg [7:0] loss_low_hi;
  reg [7:0] ind_up_lo;
  reg [7:0] ind_up_hi;
  reg [7:0] ind_low_lo;
  reg [7:0] ind_low_hi;
  reg [7:0] event_mode_reg;
  wire       event_to_dataout_enable = event_mode_reg[`MODE_ROUTE_BIT];
  wire [5:0] event_source_select     = event_mode_reg[5:0];
  wire       mode_wr    = i_reg_wr && (i_reg_addr == `ADDR_EVENT_MODE);
  wire       clear_latch = mode_wr && (i_reg_wdata == `MODE_CLEAR_VALUE);
  wire       hires_read = i_reg_rd && (i_reg_addr >= `ADDR_HIRES_FIRST) &&
                          (i_reg_addr <= `ADDR_HIRES_LAST);

  // limits stay writable while converting; no stall needed
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_up_lo     <= 8'h00;
      loss_up_hi     <= 8'h00;
      loss_low_lo    <= 8'h00;
      loss_low_hi    <= 8'h00;
      ind_up_lo      <= 8'h00;
      ind_up_hi      <= 8'h00;
      ind_low_lo     <= 8'h00;
      ind_low_hi     <= 8'h00;
      event_mode_reg <= `MODE_RESET;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `ADDR_LOSS_UP_LO:  loss_up_lo     <= i_reg_wdata;
        `ADDR_LOSS_UP_HI:  loss_up_hi     <= i_reg_wdata;
        `ADDR_LOSS_LOW_LO: loss_low_lo    <= i_reg_wdata;
        `ADDR_LOSS_LOW_HI: loss_low_hi    <= i_reg_wdata;
        `ADDR_IND_UP_LO:   ind_up_lo      <= i_reg_wdata;
        `ADDR_IND_UP_HI:   ind_up_hi      <= i_reg_wdata;
        `ADDR_IND_LOW_LO:  ind_low_lo     <= i_reg_wdata;
        `ADDR_IND_LOW_HI:  ind_low_hi     <= i_reg_wdata;
        `ADDR_EVENT_MODE:  event_mode_reg <= i_reg_wdata;
        default:           event_mode_reg <= event_mode_reg;
      endcase
    end
  end

  // only the loss-plus-inductance results reach the comparators
  wire loss_window_cmp;
  wire loss_high_latch;
  wire ind_window_cmp;
  wire ind_high_latch;
  window_comparator #(.WIDTH(WIDTH)) u_loss_cmp (
    .i_clk         (i_clk),
    .i_rst_n       (rst_n),
    .i_valid       (i_loss_ind_done),
    .i_result      (i_loss_result),
    .i_upper       ({loss_up_hi, loss_up_lo}),
    .i_lower       ({loss_low_hi, loss_low_lo}),
    .i_clear_latch (clear_latch),
    .o_window      (loss_window_cmp),
    .o_high_latch  (loss_high_latch)
  );
  window_comparator #(.WIDTH(WIDTH)) u_ind_cmp (
    .i_clk         (i_clk),
    .i_rst_n       (rst_n),
    .i_valid       (i_loss_ind_done),
    .i_result      (i_ind_result),
    .i_upper       ({ind_up_hi, ind_up_lo}),
    .i_lower       ({ind_low_hi, ind_low_lo}),
    .i_clear_latch (clear_latch),
    .o_window      (ind_window_cmp),
    .o_high_latch  (ind_high_latch)
  );

  wire [7:0] status = {2'b00, loss_high_latch, loss_window_cmp,
                       ind_high_latch, ind_window_cmp, 2'b00};

  // read port; unmapped addresses answer zero
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_LOSS_UP_LO:  o_reg_rdata <= loss_up_lo;
        `ADDR_LOSS_UP_HI:  o_reg_rdata <= loss_up_hi;
        `ADDR_LOSS_LOW_LO: o_reg_rdata <= loss_low_lo;
        `ADDR_LOSS_LOW_HI: o_reg_rdata <= loss_low_hi;
        `ADDR_IND_UP_LO:   o_reg_rdata <= ind_up_lo;
        `ADDR_IND_UP_HI:   o_reg_rdata <= ind_up_hi;
        `ADDR_IND_LOW_LO:  o_reg_rdata <= ind_low_lo;
        `ADDR_IND_LOW_HI:  o_reg_rdata <= ind_low_hi;
        `ADDR_EVENT_MODE:  o_reg_rdata <= event_mode_reg;
        `ADDR_STATUS:      o_reg_rdata <= status;
        default:           o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // hires start waits for a seen reference edge
  reg ref_seen;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_seen      <= 1'b0;
      o_hires_start <= 1'b0;
    end else begin
      if (ref_edge)
        ref_seen <= 1'b1;
      o_hires_start <= i_hires_request & (ref_seen | ref_edge);
    end
  end

  // hires ready latch; new completion wins over a read clear
  reg hires_ready;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n)
      hires_ready <= 1'b0;
    else if (i_hires_done)
      hires_ready <= 1'b1;
    else if (hires_read || clear_latch)
      hires_ready <= 1'b0;
  end

  // loss-ind ready pulse: set on completion, released near next one
  reg       loss_ind_ready;
  reg [7:0] lead_cnt;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      loss_ind_ready <= 1'b0;
      lead_cnt       <= 8'h00;
    end else begin
      if (i_loss_ind_done)
        loss_ind_ready <= 1'b1;
      else if (i_loss_ind_near || lead_cnt == 8'h01)
        loss_ind_ready <= 1'b0;
      if (i_loss_ind_near)
        lead_cnt <= LEAD[7:0];
      else if (lead_cnt != 8'h00)
        lead_cnt <= lead_cnt - 8'h01;
    end
  end

  // source mux; active when high means event present
  reg event_active;
  always @* begin
    case (event_source_select)
      `SEL_HIRES_READY:  event_active = hires_ready;
      `SEL_LOSS_IND_RDY: event_active = loss_ind_ready;
      `SEL_IND_WINDOW:   event_active = ind_window_cmp;
      `SEL_IND_HIGH:     event_active = ind_high_latch;
      `SEL_LOSS_WINDOW:  event_active = loss_window_cmp;
      `SEL_LOSS_HIGH:    event_active = loss_high_latch;
      default:           event_active = 1'b0;
    endcase
  end

  // falling sclk count for the first command byte
  reg [3:0] fall_cnt;
  reg       read_seen;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_cnt  <= 4'h0;
      read_seen <= 1'b0;
    end else if (!cs_low || cs_fall) begin
      fall_cnt  <= 4'h0;
      read_seen <= 1'b0;
    end else begin
      if (sclk_fall && fall_cnt != `SPI_CMD_BITS)
        fall_cnt <= fall_cnt + 4'h1;
      if (i_spi_read)
        read_seen <= 1'b1;
    end
  end
  wire cmd_done = (fall_cnt == `SPI_CMD_BITS);
  wire route_on = event_to_dataout_enable &&
                  (event_source_select != `SEL_NONE);

  // data-out pin drive; event is active low on the pin
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dataout    <= 1'b1;
      o_dataout_oe <= 1'b0;
      o_event_out  <= 1'b1;
    end else begin
      o_event_out <= ~event_active;
      if (!cs_low) begin
        o_dataout    <= 1'b1;
        o_dataout_oe <= 1'b0;
      end else if (route_on && !read_seen) begin
        o_dataout    <= ~event_active;
        o_dataout_oe <= 1'b1;
      end else begin
        o_dataout    <= i_serial_data;
        o_dataout_oe <= cmd_done;
      end
    end
  end
endmodule // event_sdo_reporting_comparator

// File: verification/event_sdo_properties.sv
`timescale 1ns/1ps
module event_sdo_checker #(
  parameter WIDTH = 16
) (
  input wire             i_clk,
  input wire             i_resetn,
  input wire             i_ref_clock_in,
  input wire             i_chip_select_n,
  input wire             i_reg_wr,
  input wire             i_reg_rd,
  input wire [7:0]       i_reg_addr,
  input wire [7:0]       i_reg_wdata,
  input wire             i_hires_done,
  input wire             i_loss_ind_near,
  input wire             i_loss_ind_done,
  input wire [WIDTH-1:0] i_loss_result,
  input wire [7:0]       o_reg_rdata,
  input wire             o_hires_start,
  input wire             o_dataout_oe,
  input wire             o_event_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  reg  [7:0]       mode;
  reg  [WIDTH-1:0] lup;
  reg              seen;
  wire [5:0]       sel = mode[5:0];
  wire             hrd = i_reg_rd && i_reg_addr >= 8'h38 &&
                         i_reg_addr <= 8'h3a;
  wire             lim = (i_reg_addr >= 8'h06 && i_reg_addr <= 8'h0a) ||
                         (i_reg_addr >= 8'h16 && i_reg_addr <= 8'h19);
  // shadow of host writes so checks know the selected source
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode <= 8'h00;
      lup  <= {WIDTH{1'b0}};
      seen <= 1'b0;
    end else begin
      if (i_reg_wr && i_reg_addr == 8'h0a) mode <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'h06) lup[7:0] <= i_reg_wdata;
      if (i_reg_wr && i_reg_addr == 8'h07) lup[15:8] <= i_reg_wdata;
      if (i_ref_clock_in) seen <= 1'b1;
    end
  end
  a_hires_gated: assert property (
    !seen |-> !o_hires_start) else $error("hires start without ref clock");
  a_idle_float: assert property (
    i_chip_select_n [*4] |=> !o_dataout_oe) else $error("pin driven idle");
  a_latch_set: assert property (
    (sel == 6'h01 && !i_reg_wr && i_loss_ind_done && i_loss_result > lup)
    ##1 !i_reg_wr |=> !o_event_out) else $error("loss latch missed");
  a_reg_back: assert property (
    (i_reg_wr && lim) ##1 (i_reg_rd && $stable(i_reg_addr))
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("readback wrong");
  a_ready_release: assert property (
    sel == 6'h04 && i_loss_ind_near |-> ##[1:3] o_event_out)
    else $error("ready not released");
  a_ready_assert: assert property (
    sel == 6'h04 && i_loss_ind_done |-> ##[1:3] !o_event_out)
    else $error("ready not asserted");
  a_hires_hold: assert property (
    sel == 6'h20 && !o_event_out && !hrd && !$past(hrd) && !i_reg_wr &&
    !$past(i_reg_wr) |=> !o_event_out) else $error("hires ready lost");
  a_none_high: assert property (
    sel == 6'h00 && !i_reg_wr && !$past(i_reg_wr) |=> o_event_out)
    else $error("event with no source");
  c_ready: cover property (sel == 6'h04 && i_loss_ind_done);
  c_hires: cover property (sel == 6'h20 && i_hires_done);
  c_start: cover property (o_hires_start);
endmodule // event_sdo_checker
bind event_sdo_reporting_comparator event_sdo_checker #(.WIDTH(WIDTH)) u_chk (
  .i_clk, .i_resetn, .i_ref_clock_in, .i_chip_select_n, .i_reg_wr,
  .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_hires_done, .i_loss_ind_near,
  .i_loss_ind_done, .i_loss_result, .o_reg_rdata, .o_hires_start,
  .o_dataout_oe, .o_event_out);

// File: verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire i_pin_dataout,
  input  wire i_pin_oe,
  output reg  o_chip_select_n,
  output reg  o_sclk
);
  // pull-up on the shared line: a released pin reads high
  wire    line = i_pin_oe ? i_pin_dataout : 1'b1;
  integer falls = 0;
  initial begin
    o_chip_select_n = 1'b1;
    o_sclk = 1'b0;
  end
  // falling-edge gpio, the host's only view of events
  always @(negedge line) falls = falls + 1;
  task select;
    begin
      o_chip_select_n = 1'b0;
      #300;
    end
  endtask
  // sclk stands still outside frames, 200 ns period inside
  task clocks(input integer n);
    repeat (n) begin
      #100 o_sclk = 1'b1;
      #100 o_sclk = 1'b0;
    end
  endtask
  task deselect;
    o_chip_select_n = 1'b1;
  endtask
endmodule // host_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         i_clk = 1'b0, i_resetn = 1'b0, i_ref_clock_in = 1'b0;
  reg         i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_spi_read = 1'b0;
  reg         i_serial_data = 1'b0, i_hires_request = 1'b0;
  reg         i_hires_done = 1'b0, i_loss_ind_near = 1'b0;
  reg         i_loss_ind_done = 1'b0, ref_on = 1'b0;
  reg  [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
  reg  [15:0] i_loss_result = 16'h0000, i_ind_result = 16'h0000;
  reg  [15:0] lfsr = 16'h0038;
  reg         wl = 1'b0, hl = 1'b0, wi = 1'b0, hi = 1'b0, hr = 1'b0;
  wire [7:0]  o_reg_rdata;
  wire        o_hires_start, o_dataout, o_dataout_oe, o_event_out;
  wire        i_chip_select_n, i_sclk;
  integer     err_total = 0, n_checks = 0, cyc = 0;
  integer     lup, llo, iup, ilo, sel, k;
  int         regs[$] = '{6, 7, 8, 9, 10, 22, 23, 24, 25};
  int         codes[$] = '{1, 2, 8, 16};
  event_sdo_reporting_comparator u_dut (
    .i_clk, .i_resetn, .i_ref_clock_in, .i_chip_select_n, .i_sclk,
    .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .i_spi_read,
    .i_serial_data, .i_hires_request, .i_hires_done, .i_loss_ind_near,
    .i_loss_ind_done, .i_loss_result, .i_ind_result, .o_reg_rdata,
    .o_hires_start, .o_dataout, .o_dataout_oe, .o_event_out);
  host_model u_host (.i_pin_dataout(o_dataout), .i_pin_oe(o_dataout_oe),
    .o_chip_select_n(i_chip_select_n), .o_sclk(i_sclk));
  // clocks; the reference clock is unrelated in phase
  always #12.5 i_clk = ~i_clk;
  always #31 if (ref_on) i_ref_clock_in = ~i_ref_clock_in;
  // a hang is cut short well beyond the expected run
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      stop_test;
    end
  end
  function [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic evx;
    case (sel)
      1: evx = !hl;
      2: evx = !wl;
      4: evx = 1'b0;
      8: evx = !hi;
      16: evx = !wi;
      32: evx = !hr;
      default: evx = 1'b1;
    endcase
  endfunction
  task tick;
    @(posedge i_clk) #2;
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick;
    i_reg_wr = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    tick;
    i_reg_rd = 1'b0;
    chk("rdata", e, o_reg_rdata & m);
  endtask
  // limits travel as low byte then high byte
  task limit(input [7:0] a, input [15:0] v);
    wr(a, v[7:0]);
    tick; // strobe low for one edge between writes
    wr(a + 8'h01, v[15:8]);
  endtask
  // one loss-ind conversion with random results, then status read
  task conv;
    lfsr = nxt(lfsr);
    i_loss_result = lfsr;
    lfsr = nxt(lfsr);
    i_ind_result = lfsr;
    i_loss_ind_near = 1'b1;
    tick;
    i_loss_ind_near = 1'b0;
    repeat (3) tick;
    if (sel == 4) chk("release", 1, o_event_out);
    i_loss_ind_done = 1'b1;
    tick;
    i_loss_ind_done = 1'b0;
    repeat (2) tick;
    if (i_loss_result > lup) {wl, hl} = 2'b11;
    else if (i_loss_result < llo) wl = 1'b0;
    if (i_ind_result > iup) {wi, hi} = 2'b11;
    else if (i_ind_result < ilo) wi = 1'b0;
    chk("event", evx(), o_event_out);
    rd(8'h20, 8'h3c, {2'b00, hl, wl, hi, wi, 2'b00});
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    #2 i_resetn = 1'b1;
    repeat (3) tick;
    foreach (regs[j]) begin
      lfsr = nxt(lfsr);
      wr(regs[j][7:0], lfsr[7:0]);
      rd(regs[j][7:0], 8'hff, lfsr[7:0]);
    end
    tick; // strobe low for one edge between reads
    rd(8'hff, 8'hff, 8'h00);
    lup = 16'hc000;
    llo = 16'h4000;
    iup = 16'h9000;
    ilo = 16'h3000;
    limit(8'h06, lup);
    limit(8'h08, llo);
    limit(8'h16, iup);
    limit(8'h18, ilo);
    foreach (codes[j]) begin
      sel = codes[j];
      wr(8'h0a, sel[7:0]);
      repeat (6) conv;
      wr(8'h0a, 8'h80);
      {hl, hi} = 2'b00;
      tick;
      rd(8'h20, 8'h28, 8'h00);
      wr(8'h0a, sel[7:0]);
      repeat (2) tick;
      chk("reselect", evx(), o_event_out);
    end
    sel = 4;
    wr(8'h0a, 8'h84);
    // drop the stale ready from earlier conversions before the frame
    i_loss_ind_near = 1'b1;
    tick;
    i_loss_ind_near = 1'b0;
    repeat (2) tick;
    u_host.select;
    repeat (5) tick;
    chk("oe", 1, o_dataout_oe);
    chk("pin", 1, o_dataout);
    k = u_host.falls;
    repeat (2) conv;
    chk("pin", 0, o_dataout);
    chk("gpio", k + 2, u_host.falls);
    i_serial_data = 1'b1;
    i_spi_read = 1'b1;
    tick;
    i_spi_read = 1'b0;
    repeat (3) tick;
    chk("pin", 1, o_dataout);
    u_host.deselect;
    repeat (5) tick;
    chk("oe", 0, o_dataout_oe);
    sel = 0;
    wr(8'h0a, 8'h00);
    u_host.select;
    u_host.clocks(7);
    repeat (4) tick;
    chk("oe", 0, o_dataout_oe);
    u_host.clocks(1);
    repeat (4) tick;
    chk("oe", 1, o_dataout_oe);
    u_host.deselect;
    i_hires_request = 1'b1;
    repeat (20) tick;
    chk("start", 0, o_hires_start);
    ref_on = 1'b1;
    for (k = 0; k < 100 && o_hires_start !== 1'b1; k = k + 1) tick;
    chk("start", 1, o_hires_start);
    sel = 32;
    wr(8'h0a, 8'ha0);
    i_hires_done = 1'b1;
    tick;
    i_hires_done = 1'b0;
    hr = 1'b1;
    repeat (6) tick;
    chk("hires", 0, o_event_out);
    conv;
    rd(8'h38, 8'hff, 8'h00);
    hr = 1'b0;
    repeat (2) tick;
    chk("hires", evx(), o_event_out);
    stop_test;
  end
  task stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule // tb_top
